// ===== inc/ssw_defines.vh
// Constants for the supply supervisor and watchdog block.
// Assumes a 100 MHz core clock; millisecond times are converted to cycles in the module parameter defaults.
`ifndef SSW_DEFINES_VH
`define SSW_DEFINES_VH

// ----------------------------------------------------------------------
// Clock and counter width
// ----------------------------------------------------------------------
`define SSW_CYC_PER_MS 100000
`define SSW_CNT_W 32
`define SSW_CNT_ZERO 32'h0000_0000
`define SSW_CNT_ONE 32'h0000_0001

// ----------------------------------------------------------------------
// Internal oscillator timing, in milliseconds
// ----------------------------------------------------------------------
`define SSW_FIRST_PERIOD_MS 2700
`define SSW_SHORT_PERIOD_MS 170
`define SSW_PULSE_MS 85
`define SSW_MIN_STRETCH_MS 50
`define SSW_DEBOUNCE_MS 10

// ----------------------------------------------------------------------
// External clock timing, in ticks of the timing source
// ----------------------------------------------------------------------
`define SSW_EXT_FIRST_TICKS 32'd20480
`define SSW_EXT_LATER_TICKS 32'd5120
`define SSW_EXT_PULSE_TICKS 32'd641

// ----------------------------------------------------------------------
// Reset values of single-bit state
// ----------------------------------------------------------------------
`define SSW_BIT_CLR 1'b0
`define SSW_BIT_SET 1'b1
// Synchroniser reset levels: supply failing, kick idle high, kick pin
// connected, timing input low, reset pin released high.
`define SSW_SYNC_RST_LEVELS 5'h19

`endif

// ===== logic/ssw_debounce.v
// Pushbutton debouncer producing a one-cycle pulse on a settled press.
// Assumes a synchronised input level; low means pressed.
`timescale 1ns/1ns
`include "ssw_defines.vh"

module ssw_debounce #(
    parameter [`SSW_CNT_W-1:0] STABLE_CYCLES = `SSW_DEBOUNCE_MS * `SSW_CYC_PER_MS
) (
    // Clock and reset
    input wire i_core_clk,
    input wire i_reset,
    // Button level and press pulse
    input wire i_level,
    output reg o_press
);

    reg stable_reg;
    reg [`SSW_CNT_W-1:0] cnt_reg;

    // A new level is accepted only after it has held for the whole window.
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            stable_reg <= `SSW_BIT_SET;
            cnt_reg <= `SSW_CNT_ZERO;
            o_press <= `SSW_BIT_CLR;
        end else begin
            o_press <= `SSW_BIT_CLR;
            if (i_level == stable_reg) begin
                cnt_reg <= `SSW_CNT_ZERO;
            end else if (cnt_reg + `SSW_CNT_ONE >= STABLE_CYCLES) begin
                cnt_reg <= `SSW_CNT_ZERO;
                stable_reg <= i_level;
                o_press <= ~i_level; // R16
            end else begin
                cnt_reg <= cnt_reg + `SSW_CNT_ONE;
            end
        end
    end

endmodule // ssw_debounce

// ===== logic/ssw_supervisor.v
// Supply supervisor with reset stretch, watchdog and memory write protect.
// Assumes an external comparator supplies the supply-below-trip level and
// that all pin inputs are sampled by the 100 MHz core clock.
`timescale 1ns/1ns
`include "ssw_defines.vh"

// Operation
// R1: Supply below trip point drives threshold flag and both resets active.
// R2: Threshold flag releases as soon as supply rises, no stretch wait.
// R3: Power-up reset stays active at least 50 ms after trip level.
// R4: No kick for a whole period drives expired flag and resets active.
// R5: Watchdog counting starts when both resets go inactive.
// R6: Falling kick edge before timeout clears count and restarts period.
// R7: Processor must kick within the minimum watchdog period.
// R8: Expired flag is latched active low once a full period completes.
// R9: Falling kick edge releases the expired flag and clears the count.
// R10: Unconnected kick input disables watchdog and releases expired flag.
// R11: Expired flag is held low while supply is below trip point.
// R12: Watchdog is disabled as soon as supply reaches trip point.
// R13: Timing source select chooses internal or external time base.
// R14: Power-fail output is active high with resets while out of tolerance.
// R15: Memory select output forced inactive while out of tolerance.
// R16: Debounced pushbutton on the reset pin is an external reset request.
// R17: External clock: first period 20480, later 5120, pulse 641 clocks.
// R18: Internal: first 2.7 s, pulse 85 ms, later 170 ms or 2.7 s.
// R19: Supply result and kick are synchronised in two stages first.
// R20: Press starts a full reset pulse, then watchdog uses first period.
module ssw_supervisor #(
    parameter [`SSW_CNT_W-1:0] FIRST_CYCLES = `SSW_FIRST_PERIOD_MS * `SSW_CYC_PER_MS,
    parameter [`SSW_CNT_W-1:0] SHORT_CYCLES = `SSW_SHORT_PERIOD_MS * `SSW_CYC_PER_MS,
    parameter [`SSW_CNT_W-1:0] PULSE_CYCLES = `SSW_PULSE_MS * `SSW_CYC_PER_MS,
    parameter [`SSW_CNT_W-1:0] MIN_STRETCH_CYCLES = `SSW_MIN_STRETCH_MS * `SSW_CYC_PER_MS,
    parameter [`SSW_CNT_W-1:0] DEBOUNCE_CYCLES = `SSW_DEBOUNCE_MS * `SSW_CYC_PER_MS
) (
    // Clock and reset
    input wire i_core_clk,
    input wire i_reset,
    // Supply comparison
    input wire i_supply_below_trip,
    // Timing source
    input wire i_timing_source_select,
    input wire i_timing_source_input,
    // Watchdog kick
    input wire i_watchdog_kick_n,
    input wire i_watchdog_kick_open,
    // Open-drain active-low reset pin
    input wire i_reset_pin,
    output wire o_reset_pin_out,
    output reg o_reset_pin_oe_n,
    // Active-high reset and status flags
    output reg o_reset,
    output reg o_supply_below_threshold_flag_n,
    output reg o_power_fail_flag,
    output reg o_watchdog_expired_flag_n,
    // Memory chip select
    input wire i_memory_select_in_n,
    output reg o_memory_select_out_n
);

    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    localparam [2:0] ST_FAIL = 3'h1;
    localparam [2:0] ST_PULSE = 3'h2;
    localparam [2:0] ST_RUN = 3'h4;

    // Selects the external or internal figure for a time base limit.
    function [`SSW_CNT_W-1:0] ssw_pick;
        input ext;
        input [`SSW_CNT_W-1:0] ext_val;
        input [`SSW_CNT_W-1:0] int_val;
        begin
            ssw_pick = ext ? ext_val : int_val;
        end
    endfunction

    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    wire [4:0] sync_bus;
    wire below_sync;
    wire kick_sync;
    wire open_sync;
    wire src_sync;
    wire pin_sync;
    reg kick_prev_reg;
    reg src_prev_reg;

    // The synchroniser resets to a failing supply and idle pins, so that
    // no false supply release or kick edge follows reset.
    ssw_sync2 #(
        .WIDTH(5),
        .RESET_VALUE(`SSW_SYNC_RST_LEVELS)
    ) u_sync (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_async({i_supply_below_trip, i_watchdog_kick_n, i_watchdog_kick_open,
                  i_timing_source_input, i_reset_pin}),
        .o_sync(sync_bus)
    ); // R19

    assign below_sync = sync_bus[4];
    assign kick_sync = sync_bus[3];
    assign open_sync = sync_bus[2];
    assign src_sync = sync_bus[1];
    assign pin_sync = sync_bus[0];

    always @(posedge i_core_clk) begin
        if (i_reset) begin
            kick_prev_reg <= `SSW_BIT_SET;
            src_prev_reg <= `SSW_BIT_CLR;
        end else begin
            kick_prev_reg <= kick_sync;
            src_prev_reg <= src_sync;
        end
    end

    // ------------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------------
    // Timing source select low picks the external clock, whose rising
    // edges are the ticks; the internal base ticks every core cycle.
    wire ext_mode;
    wire tick;
    wire kick_fall;
    wire [`SSW_CNT_W-1:0] pulse_limit;
    wire [`SSW_CNT_W-1:0] later_int;
    wire [`SSW_CNT_W-1:0] wd_limit;
    reg first_reg;

    assign ext_mode = ~i_timing_source_select; // R13
    assign tick = ext_mode ? (src_sync & ~src_prev_reg) : `SSW_BIT_SET; // R13
    assign kick_fall = kick_prev_reg & ~kick_sync;
    assign pulse_limit = ssw_pick(ext_mode, `SSW_EXT_PULSE_TICKS, PULSE_CYCLES); // R17 R18
    assign later_int = i_timing_source_input ? FIRST_CYCLES : SHORT_CYCLES; // R18
    assign wd_limit = first_reg ? ssw_pick(ext_mode, `SSW_EXT_FIRST_TICKS, FIRST_CYCLES)
                                : ssw_pick(ext_mode, `SSW_EXT_LATER_TICKS, later_int); // R17

    // ------------------------------------------------------------------
    // Pushbutton
    // ------------------------------------------------------------------
    // Our own drive of the pin is masked so that it is never taken for a
    // press; the debounce window also hides the pin's slow release.
    wire press;
    reg [2:0] state_reg;

    ssw_debounce #(
        .STABLE_CYCLES(DEBOUNCE_CYCLES)
    ) u_debounce (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_level(pin_sync | (state_reg != ST_RUN)),
        .o_press(press)
    );

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    reg [2:0] state_next;
    reg [`SSW_CNT_W-1:0] cnt_reg;
    reg [`SSW_CNT_W-1:0] cnt_next;
    reg [`SSW_CNT_W-1:0] min_reg;
    reg [`SSW_CNT_W-1:0] min_next;
    reg power_up_reg;
    reg power_up_next;
    reg first_next;
    reg wds_reg;
    reg wds_next;
    wire pulse_done;
    wire min_done;

    assign pulse_done = tick && (cnt_reg + `SSW_CNT_ONE >= pulse_limit);
    assign min_done = ~power_up_reg || (min_reg >= MIN_STRETCH_CYCLES);

    always @* begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        min_next = min_reg;
        power_up_next = power_up_reg;
        first_next = first_reg;
        wds_next = wds_reg;
        case (state_reg)
            ST_FAIL: begin
                cnt_next = `SSW_CNT_ZERO;
                min_next = `SSW_CNT_ZERO;
                power_up_next = `SSW_BIT_SET;
                first_next = `SSW_BIT_SET;
                if (!below_sync) begin
                    state_next = ST_PULSE; // R3
                end
            end
            ST_PULSE: begin
                if (power_up_reg && !min_done) begin
                    min_next = min_reg + `SSW_CNT_ONE; // R3
                end
                if (tick && !pulse_done) begin
                    cnt_next = cnt_reg + `SSW_CNT_ONE;
                end
                if (pulse_done || cnt_reg >= pulse_limit) begin
                    cnt_next = pulse_limit;
                end
                if ((pulse_done || cnt_reg >= pulse_limit) && min_done) begin
                    state_next = ST_RUN;
                    cnt_next = `SSW_CNT_ZERO; // R5
                    power_up_next = `SSW_BIT_CLR;
                end
            end
            ST_RUN: begin
                if (open_sync) begin
                    cnt_next = `SSW_CNT_ZERO; // R10
                    wds_next = `SSW_BIT_CLR; // R10
                end else if (kick_fall) begin
                    cnt_next = `SSW_CNT_ZERO; // R6
                    first_next = `SSW_BIT_CLR; // R6
                    wds_next = `SSW_BIT_CLR; // R9
                end else if (tick) begin
                    if (cnt_reg + `SSW_CNT_ONE >= wd_limit) begin
                        wds_next = `SSW_BIT_SET; // R8
                        state_next = ST_PULSE; // R4
                        cnt_next = `SSW_CNT_ZERO;
                        first_next = `SSW_BIT_SET;
                    end else begin
                        cnt_next = cnt_reg + `SSW_CNT_ONE;
                    end
                end
                if (press) begin
                    state_next = ST_PULSE; // R20
                    cnt_next = `SSW_CNT_ZERO; // R20
                    first_next = `SSW_BIT_SET; // R20
                end
            end
            default: begin
                state_next = ST_FAIL;
            end
        endcase
        if (open_sync) begin
            wds_next = `SSW_BIT_CLR; // R10
        end
        if (below_sync) begin
            state_next = ST_FAIL; // R1 R12
        end
    end

    always @(posedge i_core_clk) begin
        if (i_reset) begin
            state_reg <= ST_FAIL;
            cnt_reg <= `SSW_CNT_ZERO;
            min_reg <= `SSW_CNT_ZERO;
            power_up_reg <= `SSW_BIT_SET;
            first_reg <= `SSW_BIT_SET;
            wds_reg <= `SSW_BIT_CLR;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            min_reg <= min_next;
            power_up_reg <= power_up_next;
            first_reg <= first_next;
            wds_reg <= wds_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // The reset outputs are registered from the next state so they change in
    // the same cycle as the sequencer, with no decode glitches.
    assign o_reset_pin_out = `SSW_BIT_CLR;

    always @(posedge i_core_clk) begin
        if (i_reset) begin
            o_reset <= `SSW_BIT_SET;
            o_reset_pin_oe_n <= `SSW_BIT_CLR;
            o_supply_below_threshold_flag_n <= `SSW_BIT_CLR;
            o_power_fail_flag <= `SSW_BIT_SET;
            o_watchdog_expired_flag_n <= `SSW_BIT_CLR;
            o_memory_select_out_n <= `SSW_BIT_SET;
        end else begin
            o_reset <= (state_next != ST_RUN); // R1 R3 R4
            o_reset_pin_oe_n <= (state_next == ST_RUN); // R1 R3 R4
            o_supply_below_threshold_flag_n <= ~below_sync; // R1 R2
            o_power_fail_flag <= below_sync; // R14
            o_watchdog_expired_flag_n <= ~(wds_next | below_sync); // R8 R11
            o_memory_select_out_n <= below_sync | i_memory_select_in_n; // R15
        end
    end

endmodule // ssw_supervisor

// ===== logic/ssw_sync2.v
// Two-stage synchroniser for a group of level inputs.
// Assumes the inputs change slowly relative to the core clock.
`timescale 1ns/1ns
`include "ssw_defines.vh"

module ssw_sync2 #(
    parameter WIDTH = 5,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{`SSW_BIT_CLR}}
) (
    // Clock and reset
    input wire i_core_clk,
    input wire i_reset,
    // Levels
    input wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);

    reg [WIDTH-1:0] stage1_reg;
    reg [WIDTH-1:0] stage2_reg;

    // The first stage is read by the second stage only.
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            stage1_reg <= RESET_VALUE;
            stage2_reg <= RESET_VALUE;
        end else begin
            stage1_reg <= i_async;
            stage2_reg <= stage1_reg;
        end
    end

    assign o_sync = stage2_reg;

endmodule // ssw_sync2

// ===== sim/ssw_cpu_model.sv
// Processor model that services the watchdog with a falling-edge kick.
// Assumes the bench enables it and sets the kick spacing in core cycles.
`timescale 1ns/1ns
module ssw_cpu_model (
    input wire i_core_clk,
    input wire i_run,
    input wire [7:0] i_gap,
    output reg o_kick_n
);
    reg [7:0] cnt_reg;
    initial begin
        o_kick_n = 1'b1;
        cnt_reg = 8'h00;
    end
    // A one-cycle low strobe, spaced below the shortest period limit.
    always @(negedge i_core_clk) begin
        if (!i_run || cnt_reg == i_gap) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
        o_kick_n <= !(i_run && cnt_reg == i_gap);
    end
endmodule // ssw_cpu_model

// ===== sim/ssw_sup_asserts.sv
// Concurrent checks on the ports of the supply supervisor.
// Assumes one core clock domain and a synchronous active-high reset.
`timescale 1ns/1ns
module ssw_sup_asserts #(
    parameter [31:0] MIN_STRETCH_CYCLES = 32'h0000_001e
) (
    input wire i_core_clk,
    input wire i_reset,
    input wire i_supply_below_trip,
    input wire i_watchdog_kick_n,
    input wire i_watchdog_kick_open,
    input wire i_reset_pin,
    input wire o_reset,
    input wire o_reset_pin_oe_n,
    input wire o_supply_below_threshold_flag_n,
    input wire o_power_fail_flag,
    input wire o_watchdog_expired_flag_n,
    input wire o_memory_select_out_n
);
    // ------------------------------------------------------------
    // Stretch measurement
    // ------------------------------------------------------------
    // Only resets caused by a supply failure owe the minimum stretch.
    reg [31:0] hi_cnt_reg;
    reg pwr_seq_reg;
    wire thr_ok = o_supply_below_threshold_flag_n;
    always @(posedge i_core_clk) begin
        if (i_reset || !thr_ok || !o_reset) begin
            hi_cnt_reg <= 32'h0000_0000;
        end else begin
            hi_cnt_reg <= hi_cnt_reg + 32'h0000_0001;
        end
        if (i_reset || !thr_ok) begin
            pwr_seq_reg <= 1'b1;
        end else if (!o_reset) begin
            pwr_seq_reg <= 1'b0;
        end
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    sequence sup_bad; i_supply_below_trip [*4]; endsequence
    sequence sup_good; !i_supply_below_trip [*4]; endsequence
    sequence btn_held; (!i_reset_pin && !o_reset) [*8] ##1 !i_reset_pin [*6]; endsequence
    sequence kick_run; $fell(i_watchdog_kick_n) ##1 (!o_reset && thr_ok) [*4]; endsequence
    flag_follow_a: assert property (sup_bad |-> !thr_ok && o_power_fail_flag && o_reset)
        else $error("Supply low without active flags and reset.");
    release_fast_a: assert property (sup_good |-> thr_ok && !o_power_fail_flag)
        else $error("Threshold flag not released after supply recovery.");
    mem_protect_a: assert property (sup_bad |-> o_memory_select_out_n)
        else $error("Memory select not forced inactive.");
    expired_fail_a: assert property (sup_bad |-> !o_watchdog_expired_flag_n)
        else $error("Expired flag not low during supply fail.");
    reset_pair_a: assert property (o_reset != o_reset_pin_oe_n)
        else $error("Reset outputs disagree.");
    stretch_min_a: assert property ($fell(o_reset) && pwr_seq_reg |->
        hi_cnt_reg >= MIN_STRETCH_CYCLES - 32'h0000_0001)
        else $error("Power-up reset released too early.");
    wd_expire_a: assert property ($fell(o_watchdog_expired_flag_n) && thr_ok |-> o_reset)
        else $error("Expiry without reset.");
    kick_clear_a: assert property (kick_run |-> o_watchdog_expired_flag_n)
        else $error("Kick did not release expired flag.");
    open_rel_a: assert property ((i_watchdog_kick_open && thr_ok) [*4] |->
        o_watchdog_expired_flag_n)
        else $error("Open kick input did not release expired flag.");
    btn_reset_a: assert property (btn_held |-> o_reset)
        else $error("Debounced press gave no reset.");
endmodule // ssw_sup_asserts

bind ssw_supervisor ssw_sup_asserts #(.MIN_STRETCH_CYCLES(MIN_STRETCH_CYCLES)) u_ssw_sup_asserts (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_supply_below_trip(i_supply_below_trip),
    .i_watchdog_kick_n(i_watchdog_kick_n), .i_watchdog_kick_open(i_watchdog_kick_open),
    .i_reset_pin(i_reset_pin), .o_reset(o_reset), .o_reset_pin_oe_n(o_reset_pin_oe_n),
    .o_supply_below_threshold_flag_n(o_supply_below_threshold_flag_n),
    .o_power_fail_flag(o_power_fail_flag), .o_watchdog_expired_flag_n(o_watchdog_expired_flag_n),
    .o_memory_select_out_n(o_memory_select_out_n));

// ===== sim/ssw_supervisor_tb.sv
// Self-checking bench for the supply supervisor with short sim counts.
// Assumes the processor model drives the kick and the bench the rest.
`timescale 1ns/1ns
module ssw_supervisor_tb;
    reg clk, rst, sup, sel, tin_lvl, ext_on, tin, run, open, btn_n, mem_in;
    reg [7:0] gap;
    wire kick_n, pin_out, oe_n, rst_o, thr_n, pf, exp_n, mem_o;
    // The open-drain pin is low if the button or the block pulls it.
    wire pin = btn_n & (oe_n | pin_out);
    integer err_total, total_checks, n, bad;
    ssw_supervisor #(.FIRST_CYCLES(32'd200), .SHORT_CYCLES(32'd50), .PULSE_CYCLES(32'd20),
        .MIN_STRETCH_CYCLES(32'd30), .DEBOUNCE_CYCLES(32'd8)) u_ssw_supervisor (
        .i_core_clk(clk), .i_reset(rst), .i_supply_below_trip(sup),
        .i_timing_source_select(sel), .i_timing_source_input(tin),
        .i_watchdog_kick_n(kick_n), .i_watchdog_kick_open(open), .i_reset_pin(pin),
        .o_reset_pin_out(pin_out), .o_reset_pin_oe_n(oe_n), .o_reset(rst_o),
        .o_supply_below_threshold_flag_n(thr_n), .o_power_fail_flag(pf),
        .o_watchdog_expired_flag_n(exp_n), .i_memory_select_in_n(mem_in),
        .o_memory_select_out_n(mem_o));
    ssw_cpu_model u_ssw_cpu_model (.i_core_clk(clk), .i_run(run), .i_gap(gap), .o_kick_n(kick_n));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // External ticks come every second cycle so a tick is never missed.
    always @(negedge clk) tin <= ext_on ? ~tin : tin_lvl;
    task results;
        begin
            $display("checks %0d mismatches %0d", total_checks, err_total);
            if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task chk(input logic seen, input logic exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("[ERR] %0t seen %b expected %b", $time, seen, exp);
            end
        end
    endtask
    task cyc(input integer k);
        repeat (k) @(negedge clk);
    endtask
    task wt(input logic lvl, input integer lim);
        begin
            n = 0;
            while (rst_o !== lvl && n < lim) begin
                @(negedge clk);
                n = n + 1;
            end
            if (rst_o !== lvl) begin
                err_total = err_total + 1;
                $display("[ERR] %0t wait ran out", $time);
                results;
            end
        end
    endtask
    task t_power;
        begin
            cyc(4);
            chk(thr_n, 1'b0);
            chk(pf, 1'b1);
            chk(mem_o, 1'b1);
            chk(exp_n, 1'b0);
            sup = 1'b0;
            cyc(4);
            chk(thr_n, 1'b1);
            chk(rst_o, 1'b1);
            chk(oe_n, 1'b0);
            chk(pin_out, 1'b0);
            chk(pin, 1'b0);
            wt(1'b0, 100);
            chk(n + 4 >= 30 && n + 4 <= 40, 1'b1);
            chk(mem_o, 1'b0);
            $display("test power done");
        end
    endtask
    task t_timeout;
        begin
            wt(1'b1, 400);
            chk(n >= 197 && n <= 203, 1'b1);
            chk(exp_n, 1'b0);
            wt(1'b0, 100);
            chk(n >= 18 && n <= 23, 1'b1);
            chk(exp_n, 1'b0);
            $display("test timeout done");
        end
    endtask
    task t_kick;
        begin
            // Non-blocking, so the model sampling on this same edge sees it next cycle.
            tin_lvl <= 1'b0;
            run <= 1'b1;
            cyc(50);
            chk(exp_n, 1'b1);
            bad = 0;
            repeat (400) begin
                @(negedge clk);
                if (rst_o !== 1'b0) bad = 1;
            end
            chk(bad == 0, 1'b1);
            run <= 1'b0;
            wt(1'b1, 100);
            chk(n <= 54, 1'b1);
            wt(1'b0, 100);
            tin_lvl <= 1'b1;
            run <= 1'b1;
            cyc(100);
            run <= 1'b0;
            wt(1'b1, 400);
            chk(n >= 160 && n <= 203, 1'b1);
            $display("test kick done");
        end
    endtask
    task t_open_button;
        begin
            wt(1'b0, 100);
            open = 1'b1;
            cyc(6);
            chk(exp_n, 1'b1);
            cyc(300);
            chk(rst_o, 1'b0);
            mem_in = 1'b1;
            cyc(2);
            chk(mem_o, 1'b1);
            mem_in = 1'b0;
            cyc(2);
            chk(mem_o, 1'b0);
            btn_n = 1'b0;
            wt(1'b1, 30);
            chk(n >= 8, 1'b1);
            btn_n = 1'b1;
            wt(1'b0, 100);
            chk(n >= 17 && n <= 23, 1'b1);
            open = 1'b0;
            wt(1'b1, 400);
            chk(n >= 197 && n <= 203, 1'b1);
            $display("test open and button done");
        end
    endtask
    task t_ext;
        begin
            wt(1'b0, 100);
            ext_on <= 1'b1;
            sel = 1'b0;
            sup = 1'b1;
            cyc(6);
            chk(rst_o, 1'b1);
            sup = 1'b0;
            wt(1'b0, 2000);
            chk(n >= 1275 && n <= 1295, 1'b1);
            $display("test external clock done");
        end
    endtask
    initial begin
        {rst, sup, sel, tin_lvl, btn_n} = 5'h1f;
        {ext_on, tin, run, open, mem_in} = 5'h00;
        gap = 8'h28;
        err_total = 0;
        total_checks = 0;
        cyc(2);
        rst = 1'b0;
        t_power;
        t_timeout;
        t_kick;
        t_open_button;
        t_ext;
        results;
    end
endmodule // ssw_supervisor_tb
